/* design/sbm_pkg.sv */
// package: constants and types of the base mode register decoder
package sbm_pkg;
	// ************************************************************
	// register fields
	// ************************************************************
	localparam int          MODE_W         = 16;
	localparam logic [15:0] MODE_RST       = 16'h0000;
	localparam logic [15:0] MODE_RSVD_MASK = 16'he080;
	localparam int          BL_LSB         = 0;
	localparam int          BT_BIT         = 3;
	localparam int          RL_LSB         = 4;
	localparam int          DLLRST_BIT     = 8;
	localparam int          WR_LSB         = 9;
	localparam int          PD_BIT         = 12;
	localparam int          COL_W          = 10;
	localparam int          CMD_BURST_SEL  = 12;

	// burst length field codes
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF    = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int          CLK_MHZ          = 200;
	localparam int          DLL_LOCK_CYC     = 512;
	localparam logic [9:0]  DLL_LOCK_CNT     = 10'(DLL_LOCK_CYC);
	localparam logic [3:0]  RL_MIN           = 4'h5;
	localparam logic [3:0]  RL_MAX           = 4'he;
	localparam logic [3:0]  WR_DEFAULT       = 4'h5;

	typedef enum logic [1:0] {
		SBM_IDLE  = 2'b00,
		SBM_WAIT  = 2'b01,
		SBM_BURST = 2'b10
	} sbm_state_e;
endpackage : sbm_pkg

/* design/sbm_beat_order.sv */
// beat column order generator for one burst beat
`timescale 1ns/1ps
`default_nettype none
module sbm_beat_order (
	// request
	input  wire logic [2:0] start_i,
	input  wire logic [2:0] beat_i,
	input  wire logic       interleave_i,
	input  wire logic       write_i,
	input  wire logic       chop_i,
	// result
	output logic      [2:0] col_o
);
	logic [2:0] base;
	logic [1:0] rot;
	always_comb begin
		// writes ignore the low start bits; chop keeps bit 2
		base = write_i ? {(chop_i ? start_i[2] : 1'b0), 2'b00} : start_i;
		rot  = 2'(base[1:0] + beat_i[1:0]);
		if (interleave_i) begin
			col_o = base ^ beat_i;
		end else begin
			col_o = {base[2] ^ beat_i[2], rot};
		end
	end
endmodule : sbm_beat_order
`default_nettype wire

/* design/sbm_wr_decode.sv */
// write recovery and read latency field decoder
`timescale 1ns/1ps
`default_nettype none
module sbm_wr_decode (
	// fields
	input  wire logic [2:0] wr_code_i,
	input  wire logic [2:0] rl_code_i,
	// cycles
	output logic      [3:0] wr_cyc_o,
	output logic      [3:0] rl_cyc_o
);
	always_comb begin
		unique case (wr_code_i)
			3'h1:    wr_cyc_o = 4'h5;
			3'h2:    wr_cyc_o = 4'h6;
			3'h3:    wr_cyc_o = 4'h7;
			3'h4:    wr_cyc_o = 4'h8;
			3'h5:    wr_cyc_o = 4'ha;
			3'h6:    wr_cyc_o = 4'hc;
			default: wr_cyc_o = sbm_pkg::WR_DEFAULT;
		endcase
		// three bits reach 5..12, so the clamp at RL_MAX (14) never applies
		rl_cyc_o = 4'(rl_code_i) + sbm_pkg::RL_MIN;
		if (rl_cyc_o > sbm_pkg::RL_MAX) begin
			rl_cyc_o = sbm_pkg::RL_MAX;
		end
	end
endmodule : sbm_wr_decode
`default_nettype wire

/* design/sbm_mode_reg.sv */
// base mode register of the sdram with burst sequencing
`timescale 1ns/1ps
`default_nettype none
module sbm_mode_reg (
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RESETN_I,
	input  wire logic        CKE_I,
	// mode set command
	input  wire logic        MODE_SET_I,
	input  wire logic [15:0] MODE_DATA_I,
	// read and write commands
	input  wire logic        RD_CMD_I,
	input  wire logic        WR_CMD_I,
	input  wire logic [9:0]  COL_I,
	input  wire logic        PER_COMMAND_BURST_SELECT_I,
	// power-down
	input  wire logic        PRECHARGE_PD_I,
	// beat outputs
	output logic             BEAT_VALID_O,
	output logic             BEAT_WRITE_O,
	output logic [9:0]       BEAT_COL_O,
	output logic             DQ_OE_O,
	output logic             DQS_OE_O,
	// status
	output logic [15:0]      BASE_MODE_REGISTER_O,
	output logic             FOUR_BEAT_CHOP_O,
	output logic             DLL_RESET_O,
	output logic             DLL_LOCKED_O,
	output logic             DLL_RUN_O,
	output logic [3:0]       WR_CYCLES_O,
	output logic [3:0]       READ_LATENCY_CYCLES_O
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [5:0]  s1_q, s2_q;
	logic [15:0] md1_q, md2_q;
	logic [9:0]  col1_q, col2_q;
	logic [5:0]  s_d;
	assign s_d = {CKE_I, MODE_SET_I, RD_CMD_I, WR_CMD_I, PER_COMMAND_BURST_SELECT_I,
		PRECHARGE_PD_I};
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			s1_q   <= '0;
			s2_q   <= '0;
			md1_q  <= '0;
			md2_q  <= '0;
			col1_q <= '0;
			col2_q <= '0;
		end else begin
			s1_q   <= s_d;
			s2_q   <= s1_q;
			md1_q  <= MODE_DATA_I;
			md2_q  <= md1_q;
			col1_q <= COL_I;
			col2_q <= col1_q;
		end
	end
	logic en, mset, rd, wr, otf_sel, ppd;
	assign en      = s2_q[5];
	assign mset    = s2_q[4];
	assign rd      = s2_q[3];
	assign wr      = s2_q[2];
	assign otf_sel = s2_q[1];
	assign ppd     = s2_q[0];

	// ************************************************************
	// mode register
	// ************************************************************
	logic [15:0] mode_q, mode_d;
	logic        dllrst_q, dllrst_d;
	logic [9:0]  lock_q, lock_d;
	always_comb begin
		mode_d   = mode_q;
		dllrst_d = 1'b0;
		lock_d   = lock_q;
		// controller keeps reserved bits zero; mask them anyway
		if (mset) begin
			mode_d = md2_q & ~sbm_pkg::MODE_RSVD_MASK;
		end
		// bit 8 seen once then cleared by hardware
		if (mode_q[sbm_pkg::DLLRST_BIT]) begin
			dllrst_d                       = 1'b1;
			lock_d                         = sbm_pkg::DLL_LOCK_CNT;
			if (!mset) begin
				mode_d[sbm_pkg::DLLRST_BIT] = 1'b0;
			end
		end else if (lock_q != 10'h000) begin
			lock_d = lock_q - 10'h001;
		end
	end
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			mode_q   <= sbm_pkg::MODE_RST;
			dllrst_q <= 1'b0;
			lock_q   <= '0;
		end else if (en) begin
			mode_q   <= mode_d;
			dllrst_q <= dllrst_d;
			lock_q   <= lock_d;
		end
	end

	// ************************************************************
	// field decode
	// ************************************************************
	logic [1:0] bl;
	logic       interleave;
	logic [3:0] wr_cyc, rl_cyc;
	assign bl         = mode_q[sbm_pkg::BL_LSB +: 2];
	assign interleave = mode_q[sbm_pkg::BT_BIT];
	sbm_wr_decode u_dec (
		.wr_code_i (mode_q[sbm_pkg::WR_LSB +: 3]),
		.rl_code_i (mode_q[sbm_pkg::RL_LSB +: 3]),
		.wr_cyc_o  (wr_cyc),
		.rl_cyc_o  (rl_cyc)
	);
	logic cmd_chop;
	always_comb begin
		unique case (bl)
			sbm_pkg::BL_FIXED8: cmd_chop = 1'b0;
			sbm_pkg::BL_OTF:    cmd_chop = !otf_sel;
			sbm_pkg::BL_FIXED4: cmd_chop = 1'b1;
			default:            cmd_chop = 1'b0;
		endcase
	end

	// ************************************************************
	// burst sequencer
	// ************************************************************
	sbm_pkg::sbm_state_e st_q, st_d;
	logic [3:0] wait_q, wait_d;
	logic [2:0] beat_q, beat_d, start_q, start_d;
	logic [6:0] blk_q, blk_d;
	logic       chop_q, chop_d, isw_q, isw_d;
	logic       bv_d, dq_oe_d;
	logic [2:0] col_lo;
	sbm_beat_order u_ord (
		.start_i      (start_q),
		.beat_i       (beat_q),
		.interleave_i (interleave),
		.write_i      (isw_q),
		.chop_i       (chop_q),
		.col_o        (col_lo)
	);
	always_comb begin
		st_d    = st_q;
		wait_d  = wait_q;
		beat_d  = beat_q;
		start_d = start_q;
		blk_d   = blk_q;
		chop_d  = chop_q;
		isw_d   = isw_q;
		bv_d    = 1'b0;
		dq_oe_d = 1'b0;
		unique case (st_q)
			sbm_pkg::SBM_IDLE: begin
				if (rd || wr) begin
					// internal start identical for chop and eight
					st_d    = sbm_pkg::SBM_WAIT;
					wait_d  = wr ? wr_cyc : rl_cyc;
					beat_d  = 3'h0;
					start_d = col2_q[2:0];
					blk_d   = col2_q[9:3];
					chop_d  = cmd_chop;
					isw_d   = wr;
				end
			end
			sbm_pkg::SBM_WAIT: begin
				wait_d = wait_q - 4'h1;
				if (wait_q <= 4'h1) begin
					st_d = sbm_pkg::SBM_BURST;
				end
			end
			sbm_pkg::SBM_BURST: begin
				// chopped read keeps full slot time but drives only four
				bv_d    = !(chop_q && beat_q[2]);
				dq_oe_d = bv_d && !isw_q;
				beat_d  = 3'(beat_q + 3'h1);
				if (beat_q == 3'h7) begin
					st_d = sbm_pkg::SBM_IDLE;
				end
			end
			default: st_d = sbm_pkg::SBM_IDLE;
		endcase
	end
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			st_q    <= sbm_pkg::SBM_IDLE;
			wait_q  <= '0;
			beat_q  <= '0;
			start_q <= '0;
			blk_q   <= '0;
			chop_q  <= 1'b0;
			isw_q   <= 1'b0;
		end else if (en) begin
			st_q    <= st_d;
			wait_q  <= wait_d;
			beat_q  <= beat_d;
			start_q <= start_d;
			blk_q   <= blk_d;
			chop_q  <= chop_d;
			isw_q   <= isw_d;
		end
	end

	// ************************************************************
	// registered outputs
	// ************************************************************
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			BEAT_VALID_O          <= 1'b0;
			BEAT_WRITE_O          <= 1'b0;
			BEAT_COL_O            <= '0;
			DQ_OE_O               <= 1'b0;
			DQS_OE_O              <= 1'b0;
			BASE_MODE_REGISTER_O  <= sbm_pkg::MODE_RST;
			FOUR_BEAT_CHOP_O      <= 1'b0;
			DLL_RESET_O           <= 1'b0;
			DLL_LOCKED_O          <= 1'b0;
			DLL_RUN_O             <= 1'b0;
			WR_CYCLES_O           <= sbm_pkg::WR_DEFAULT;
			READ_LATENCY_CYCLES_O <= sbm_pkg::RL_MIN;
		end else if (en) begin
			BEAT_VALID_O          <= bv_d;
			BEAT_WRITE_O          <= bv_d && isw_q;
			BEAT_COL_O            <= {blk_q, col_lo};
			DQ_OE_O               <= dq_oe_d;
			DQS_OE_O              <= dq_oe_d;
			BASE_MODE_REGISTER_O  <= mode_q;
			FOUR_BEAT_CHOP_O      <= chop_q;
			DLL_RESET_O           <= dllrst_q;
			DLL_LOCKED_O          <= lock_q == 10'h000 && !dllrst_q;
			// dll off in precharge power-down unless kept
			DLL_RUN_O             <= !(ppd && !mode_q[sbm_pkg::PD_BIT]);
			WR_CYCLES_O           <= wr_cyc;
			READ_LATENCY_CYCLES_O <= rl_cyc;
		end
	end
endmodule : sbm_mode_reg
`default_nettype wire

/* tb/sbm_chk_sva.sv */
// checker: port assertions of the base mode register block
`timescale 1ns/1ps
`default_nettype none
module sbm_chk (
	// clock and inputs
	input wire logic        CLK_I,
	input wire logic        RESETN_I,
	input wire logic        CKE_I,
	input wire logic        PRECHARGE_PD_I,
	// outputs
	input wire logic        BEAT_VALID_O,
	input wire logic        BEAT_WRITE_O,
	input wire logic [9:0]  BEAT_COL_O,
	input wire logic        DQ_OE_O,
	input wire logic [15:0] BASE_MODE_REGISTER_O,
	input wire logic        DLL_RESET_O,
	input wire logic        DLL_LOCKED_O,
	input wire logic        DLL_RUN_O,
	input wire logic [3:0]  WR_CYCLES_O,
	input wire logic [3:0]  READ_LATENCY_CYCLES_O
);
	// ****
	// properties
	// ****
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	logic [15:0] m;
	assign m = BASE_MODE_REGISTER_O;
	// unused codes fall back to the shortest recovery
	function automatic logic [3:0] wr_of(input logic [2:0] c);
		return (c == 3'h0 || c == 3'h7) ? 4'h5 :
			(c < 3'h5) ? 4'(c) + 4'h4 : (c[0] ? 4'ha : 4'hc);
	endfunction
	sequence s_dll_go;
		$rose(m[8]);
	endsequence
	sequence s_lock_low;
		!DLL_LOCKED_O [*8];
	endsequence
	chk_rsvd_zero: assert property ((m & 16'he080) == 16'h0000)
		else $error("reserved mode bit set");
	chk_dll_clear: assert property (s_dll_go |=> !m[8])
		else $error("dll reset bit not cleared");
	chk_dll_pulse: assert property (s_dll_go |-> (##[0:2] DLL_RESET_O) or $past(DLL_RESET_O))
		else $error("dll reset not started");
	chk_dll_hold: assert property (DLL_RESET_O |=> s_lock_low)
		else $error("dll locked too early");
	chk_dll_off: assert property ((CKE_I && PRECHARGE_PD_I && !m[12]) [*4] |-> !DLL_RUN_O)
		else $error("dll runs in power-down");
	chk_dll_on: assert property ((CKE_I && m[12]) [*4] |-> DLL_RUN_O)
		else $error("dll stopped");
	chk_wr_map: assert property ($stable(m) [*3] |-> WR_CYCLES_O == wr_of(m[11:9]))
		else $error("write recovery decode wrong");
	chk_rl_map: assert property ($stable(m) [*3] |-> READ_LATENCY_CYCLES_O == 4'(m[6:4]) + 4'h5)
		else $error("read latency decode wrong");
	chk_block_keep: assert property (BEAT_VALID_O ##1 BEAT_VALID_O |-> BEAT_COL_O[9:3] == $past(BEAT_COL_O[9:3]))
		else $error("burst left its block");
	chk_read_drive: assert property (DQ_OE_O |-> BEAT_VALID_O && !BEAT_WRITE_O)
		else $error("data driven outside read beat");
endmodule : sbm_chk
bind sbm_mode_reg sbm_chk i_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .CKE_I(CKE_I),
	.PRECHARGE_PD_I(PRECHARGE_PD_I), .BEAT_VALID_O(BEAT_VALID_O), .BEAT_WRITE_O(BEAT_WRITE_O),
	.BEAT_COL_O(BEAT_COL_O), .DQ_OE_O(DQ_OE_O), .BASE_MODE_REGISTER_O(BASE_MODE_REGISTER_O),
	.DLL_RESET_O(DLL_RESET_O), .DLL_LOCKED_O(DLL_LOCKED_O), .DLL_RUN_O(DLL_RUN_O),
	.WR_CYCLES_O(WR_CYCLES_O), .READ_LATENCY_CYCLES_O(READ_LATENCY_CYCLES_O));
`default_nettype wire

/* tb/sbm_ctrl_model.sv */
// controller model: drives commands into the mode register block
`timescale 1ns/1ps
`default_nettype none
module sbm_ctrl_model #(
	parameter int SLOW_EXIT = 10,
	parameter int FAST_EXIT = 3
) (
	// clock
	input  wire logic        clk_i,
	// command side
	output logic             cke_o,
	output logic             set_o,
	output logic      [15:0] data_o,
	output logic             rd_o,
	output logic             wr_o,
	output logic      [9:0]  col_o,
	output logic             sel_o,
	output logic             pd_o
);
	// ****
	// command tasks
	// ****
	int          dll_wait = 0;
	logic [15:0] mode     = 16'h0000;
	initial begin
		cke_o = 1'b1;
		set_o = 1'b0;
		data_o = 16'h0000;
		rd_o = 1'b0;
		wr_o = 1'b0;
		col_o = 10'h000;
		sel_o = 1'b0;
		pd_o = 1'b0;
	end
	// only clocks with enable high count toward lock
	always @(posedge clk_i) begin
		if (dll_wait > 0 && cke_o) begin
			dll_wait--;
		end
	end
	task automatic mode_set(input logic [15:0] v);
		@(negedge clk_i);
		mode = v & ~sbm_pkg::MODE_RSVD_MASK;
		data_o = mode;
		set_o = 1'b1;
		if (v[8]) dll_wait = 512;
		@(negedge clk_i);
		set_o = 1'b0;
		data_o = ~mode;
	endtask : mode_set
	task automatic cmd(input logic w, input logic [9:0] c, input logic s);
		@(negedge clk_i);
		while (!w && dll_wait > 0) @(negedge clk_i);
		rd_o = !w;
		wr_o = w;
		col_o = c;
		sel_o = s;
		@(negedge clk_i);
		rd_o = 1'b0;
		wr_o = 1'b0;
		col_o = ~c;
		sel_o = ~s;
	endtask : cmd
	// recovery time in tenths of ns, rounded up to whole 5 ns clocks
	function automatic logic [2:0] wr_code(input int tenth_ns);
		int c;
		c = (tenth_ns + 49) / 50;
		if (c <= 5) return 3'h1;
		if (c <= 8) return 3'(c - 4);
		if (c <= 10) return 3'h5;
		return 3'h6;
	endfunction : wr_code
	task automatic pd(input logic v);
		@(negedge clk_i);
		pd_o = v;
		if (!v) repeat (mode[12] ? FAST_EXIT : SLOW_EXIT) @(negedge clk_i);
	endtask : pd
endmodule : sbm_ctrl_model
`default_nettype wire

/* tb/tb_top.sv */
// testbench: base mode register block with controller model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        cke, mset, rd, wr, sel, pd, bv, bw, dqoe, dllr, dlll, dllrun, dqsoe, chopo;
	logic [15:0] mdat, mreg;
	logic [9:0]  col, bcol;
	logic [3:0]  wrc, rlc;
	int          miscompares = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          wr_tab[8] = '{5, 5, 6, 7, 8, 10, 12, 5};
	int          lat_q[16];
	initial forever #2.5 clk = ~clk;
	sbm_ctrl_model i_ctrl (.clk_i(clk), .cke_o(cke), .set_o(mset), .data_o(mdat), .rd_o(rd),
		.wr_o(wr), .col_o(col), .sel_o(sel), .pd_o(pd));
	sbm_mode_reg i_dut (.CLK_I(clk), .RESETN_I(rstn), .CKE_I(cke), .MODE_SET_I(mset),
		.MODE_DATA_I(mdat), .RD_CMD_I(rd), .WR_CMD_I(wr), .COL_I(col),
		.PER_COMMAND_BURST_SELECT_I(sel), .PRECHARGE_PD_I(pd), .BEAT_VALID_O(bv),
		.BEAT_WRITE_O(bw), .BEAT_COL_O(bcol), .DQ_OE_O(dqoe), .DQS_OE_O(dqsoe),
		.BASE_MODE_REGISTER_O(mreg), .FOUR_BEAT_CHOP_O(chopo), .DLL_RESET_O(dllr),
		.DLL_LOCKED_O(dlll), .DLL_RUN_O(dllrun), .WR_CYCLES_O(wrc), .READ_LATENCY_CYCLES_O(rlc));
	// ****
	// tasks
	// ****
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic finish_test();
		if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			finish_test();
		end
	end
	task automatic setm(input logic [15:0] v);
		i_ctrl.mode_set(v);
		repeat (6) @(negedge clk);
	endtask : setm
	function automatic logic [9:0] ecol(logic [9:0] c, logic w, logic il, logic ch, logic [2:0] i);
		logic       hi;
		logic [1:0] lo;
		hi = w ? (ch ? c[2] : i[2]) : c[2] ^ i[2];
		lo = w ? i[1:0] : il ? c[1:0] ^ i[1:0] : c[1:0] + i[1:0];
		return {c[9:3], hi, lo};
	endfunction : ecol
	task automatic burst(input logic w, input logic [9:0] c9, input logic s, il, ch,
		output int lat);
		lat = 0;
		i_ctrl.cmd(w, 10'(c9), s);
		while (bv !== 1'b1 && lat < 64) begin
			@(negedge clk);
			lat++;
		end
		for (int i = 0; i < 8; i++) begin
			check("beat_valid", 16'(bv), 16'(!ch || i < 4));
			check("read_drive", 16'(dqoe), 16'(!w && (!ch || i < 4)));
			check("strobe_drive", 16'(dqsoe), 16'(!w && (!ch || i < 4)));
			check("chop_flag", 16'(chopo), 16'(ch));
			if (!ch || i < 4) begin
				check("beat_col", 16'(bcol), 16'(ecol(10'(c9), w, il, ch, 3'(i))));
				check("beat_write", 16'(bw), 16'(w));
			end
			@(negedge clk);
		end
	endtask : burst
	initial begin
		int         n;
		logic [1:0] code;
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		check("mode_reset", mreg, 16'h0000);
		check("wr_reset", 16'(wrc), 16'h0005);
		i_ctrl.mode_set(16'h0100);
		n = 0;
		while (dllr !== 1'b1 && n < 16) begin
			@(negedge clk);
			n++;
		end
		check("dll_pulse", 16'(dllr), 16'h0001);
		n = 0;
		while (dlll !== 1'b1 && n < 600) begin
			@(negedge clk);
			n++;
		end
		check("dll_bit_clear", 16'(mreg[8]), 16'h0000);
		check("dll_lock_wait", 16'(n >= 511 && n <= 513), 16'h0001);
		for (int j = 0; j < 8; j++) begin
			setm({4'h1, 3'(j), 2'h0, 3'(j), 4'h0});
			check("mode_value", mreg, {4'h1, 3'(j), 2'h0, 3'(j), 4'h0});
			check("wr_cycles", 16'(wrc), 16'(wr_tab[j]));
			check("read_latency", 16'(rlc), 16'(j + 5));
		end
		setm({4'h1, i_ctrl.wr_code(370), 9'h000});
		check("wr_roundup", 16'(wrc), 16'h0008);
		setm({4'h1, i_ctrl.wr_code(350), 9'h000});
		check("wr_exact", 16'(wrc), 16'h0007);
		i_ctrl.pd(1'b1);
		repeat (6) @(negedge clk);
		check("dll_run_keep", 16'(dllrun), 16'h0001);
		i_ctrl.pd(1'b0);
		setm(16'h0000);
		i_ctrl.pd(1'b1);
		repeat (6) @(negedge clk);
		check("dll_run_off", 16'(dllrun), 16'h0000);
		i_ctrl.pd(1'b0);
		// b[3:2] picks length mode, b[1] order type, b[0] write
		for (int b = 0; b < 16; b++) begin
			code = (b[3:2] == 2'h3) ? 2'h2 : (b[3:2] == 2'h0) ? 2'h0 : 2'h1;
			if (!b[0]) setm({4'h1, 3'h1, 5'h0, b[1], 1'b0, code});
			burst(b[0], {7'h2a, 3'(b + 3)}, b[3], b[1], b[2], lat_q[b]);
		end
		for (int x = 0; x < 4; x++) begin
			check("otf_start", 16'(lat_q[4 + x]), 16'(lat_q[8 + x]));
			check("fixed_start", 16'(lat_q[x]), 16'(lat_q[12 + x]));
		end
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
